// ===== clock_select_rti_watchdog.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module clock_select_rti_watchdog #(
  parameter int MON_CYCLES = clk_fn_pkg::CM_CYCLES
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_ce,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_special_mode,
  input  wire logic       i_wait_mode,
  input  wire logic       i_debug_mode,
  input  wire logic       i_limp_home,
  input  wire logic       i_osc_tick,
  input  wire logic       i_crystal_timing_clock_tick,
  output logic            o_sys_sel_pll,
  output logic            o_sys_sel_slow,
  output logic            o_clock_select,
  output logic            o_cpu_halt,
  output logic            o_module_slow_sel,
  output logic            o_periph_from_vco,
  output logic            o_can_from_sys,
  output logic            o_debug_from_e,
  output logic      [5:0] o_slow_div,
  output logic      [7:0] o_pll_mul,
  output logic      [7:0] o_pll_ref,
  output logic            o_periodic_irq,
  output logic            o_wdg_reset,
  output logic            o_mon_reset
);
  initial begin
    if (MON_CYCLES < 1) $error("monitor count too small");
    if (MON_CYCLES > 65535) $error("monitor count exceeds counter width");
  end

  // pin inputs synchronised
  logic [1:0] osc_s, crystal_timing_clock_s, wait_s, dbg_s, limp_s;
  logic osc_prev, crystal_timing_clock_prev;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      osc_s <= 2'h0; crystal_timing_clock_s <= 2'h0; wait_s <= 2'h0; dbg_s <= 2'h0; limp_s <= 2'h0;
      osc_prev <= 1'b0; crystal_timing_clock_prev <= 1'b0;
    end else if (i_ce) begin
      osc_s  <= {osc_s[0], i_osc_tick};
      crystal_timing_clock_s <= {crystal_timing_clock_s[0], i_crystal_timing_clock_tick};
      wait_s <= {wait_s[0], i_wait_mode};
      dbg_s  <= {dbg_s[0], i_debug_mode};
      limp_s <= {limp_s[0], i_limp_home};
      osc_prev  <= osc_s[1];
      crystal_timing_clock_prev <= crystal_timing_clock_s[1];
    end
  end
  wire osc_edge  = osc_s[1] ^ osc_prev;
  wire crystal_timing_clock_rise = crystal_timing_clock_s[1] & ~crystal_timing_clock_prev;
  wire limp      = limp_s[1];

  // registers
  logic [7:0] rti_ctrl_reg, wd_ctrl_reg, clk_sel_reg;
  logic [5:0] slow_div_reg;
  logic [7:0] pll_mul_reg, pll_ref_reg;
  logic       flag_reg, once_sw_reg, once_sb_reg, once_wd_reg;
  wire wr_rti  = i_wr && i_addr == clk_fn_pkg::ADDR_RTI_CTRL;
  wire wr_flag = i_wr && i_addr == clk_fn_pkg::ADDR_RTI_FLAG;
  wire wr_wdc  = i_wr && i_addr == clk_fn_pkg::ADDR_WDG_CTRL;
  wire wr_svc  = i_wr && i_addr == clk_fn_pkg::ADDR_WDG_SVC;
  wire wr_cs   = i_wr && i_addr == clk_fn_pkg::ADDR_CLK_SEL;
  wire bus_pll_select_eff = clk_sel_reg[clk_fn_pkg::CS_BUS_PLL_SELECT_BIT] | limp;
  // write-once gating for normal modes
  wire sw_ok = i_special_mode | ~once_sw_reg;
  wire sb_ok = i_special_mode | ~once_sb_reg;
  wire wd_ok = i_special_mode | ~once_wd_reg;
  logic [7:0] rti_next;
  always_comb begin
    rti_next = rti_ctrl_reg;
    rti_next[7] = i_wdata[7];
    rti_next[2:0] = i_wdata[2:0];
    if (sw_ok) rti_next[clk_fn_pkg::RTI_SW_BIT] = i_wdata[clk_fn_pkg::RTI_SW_BIT];
    if (sb_ok) rti_next[clk_fn_pkg::RTI_SB_BIT] = i_wdata[clk_fn_pkg::RTI_SB_BIT];
    if (i_special_mode) rti_next[clk_fn_pkg::RTI_BY_BIT] = i_wdata[clk_fn_pkg::RTI_BY_BIT];
  end
  logic [7:0] wdc_next;
  always_comb begin
    wdc_next = wd_ctrl_reg;
    wdc_next[clk_fn_pkg::WD_CME_BIT] = i_wdata[clk_fn_pkg::WD_CME_BIT];
    if (wd_ok) begin
      wdc_next[clk_fn_pkg::WD_WIN_BIT] = i_wdata[clk_fn_pkg::WD_WIN_BIT];
      wdc_next[2:0] = i_wdata[2:0];
    end
    if (i_special_mode) wdc_next[clk_fn_pkg::WD_DIS_BIT] = i_wdata[clk_fn_pkg::WD_DIS_BIT];
  end

  logic flag_set;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rti_ctrl_reg <= 8'h00; wd_ctrl_reg <= clk_fn_pkg::WD_CTRL_RST; clk_sel_reg <= 8'h00;
      slow_div_reg <= 6'h00; pll_mul_reg <= 8'h00; pll_ref_reg <= 8'h00; flag_reg <= 1'b0;
      once_sw_reg <= 1'b0; once_sb_reg <= 1'b0; once_wd_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_rti) begin
        rti_ctrl_reg <= rti_next;
        if (i_wdata[clk_fn_pkg::RTI_SW_BIT] != rti_ctrl_reg[clk_fn_pkg::RTI_SW_BIT] || 1'b1)
          once_sw_reg <= 1'b1;
        once_sb_reg <= 1'b1;
      end
      if (wr_wdc) begin
        wd_ctrl_reg <= wdc_next;
        once_wd_reg <= 1'b1;
      end
      if (wr_cs) clk_sel_reg <= i_wdata;
      if (i_wr && i_addr == clk_fn_pkg::ADDR_SLOW_DIV) slow_div_reg <= i_wdata[5:0];
      if (i_wr && i_addr == clk_fn_pkg::ADDR_PLL_MUL && !bus_pll_select_eff) pll_mul_reg <= i_wdata;
      if (i_wr && i_addr == clk_fn_pkg::ADDR_PLL_REF && !bus_pll_select_eff) pll_ref_reg <= i_wdata;
      if (flag_set) flag_reg <= 1'b1;
      else if (wr_flag && i_wdata[clk_fn_pkg::RTI_FLAG_BIT]) flag_reg <= 1'b0;
    end
  end

  // read mux; module select reads latched value
  logic [7:0] rd_mux;
  always_comb begin
    unique case (i_addr)
      clk_fn_pkg::ADDR_RTI_CTRL: rd_mux = rti_ctrl_reg;
      clk_fn_pkg::ADDR_RTI_FLAG: rd_mux = {flag_reg, 7'h00};
      clk_fn_pkg::ADDR_WDG_CTRL: rd_mux = wd_ctrl_reg;
      clk_fn_pkg::ADDR_CLK_SEL:  rd_mux = clk_sel_reg;
      clk_fn_pkg::ADDR_SLOW_DIV: rd_mux = {2'h0, slow_div_reg};
      clk_fn_pkg::ADDR_PLL_MUL:  rd_mux = pll_mul_reg;
      clk_fn_pkg::ADDR_PLL_REF:  rd_mux = pll_ref_reg;
      default:                   rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) o_rdata <= 8'h00;
    else if (i_ce) o_rdata <= i_rd ? rd_mux : 8'h00;
  end

  // clock selects to the clock tree
  // pll select wins
  wire sel_pll  = bus_pll_select_eff;
  wire sel_slow = ~bus_pll_select_eff & clk_sel_reg[clk_fn_pkg::CS_BUS_SLOW_SELECT_BIT];
  logic [2:0] sw_cnt_reg;
  logic       prev_pll_reg, prev_slow_reg;
  wire switching = (sel_pll != prev_pll_reg) || (sel_slow != prev_slow_reg);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      sw_cnt_reg <= 3'h0; prev_pll_reg <= 1'b0; prev_slow_reg <= 1'b0;
    end else if (i_ce) begin
      prev_pll_reg  <= sel_pll;
      prev_slow_reg <= sel_slow;
      if (switching) sw_cnt_reg <= 3'(clk_fn_pkg::SWITCH_CYC);
      else if (sw_cnt_reg != 3'h0) sw_cnt_reg <= sw_cnt_reg - 3'h1;
    end
  end
  wire busy = switching || sw_cnt_reg != 3'h0;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_sys_sel_pll <= 1'b0; o_sys_sel_slow <= 1'b0; o_clock_select <= 1'b0;
      o_cpu_halt <= 1'b0; o_module_slow_sel <= 1'b0; o_periph_from_vco <= 1'b0;
      o_can_from_sys <= 1'b0; o_debug_from_e <= 1'b0; o_slow_div <= 6'h00;
      o_pll_mul <= 8'h00; o_pll_ref <= 8'h00;
    end else if (i_ce) begin
      o_sys_sel_pll  <= sel_pll;
      o_sys_sel_slow <= sel_slow;
      o_clock_select <= ~busy;
      o_cpu_halt     <= busy;
      // module select forced low in limp-home
      o_module_slow_sel <= clk_sel_reg[clk_fn_pkg::CS_MCS_BIT] & ~limp;
      o_periph_from_vco <= limp;
      o_can_from_sys <= clk_sel_reg[clk_fn_pkg::CS_CAN_BIT];
      o_debug_from_e <= clk_sel_reg[clk_fn_pkg::CS_DBG_BIT];
      // divider settings drive the clock tree dividers
      o_slow_div <= slow_div_reg;
      o_pll_mul  <= pll_mul_reg;
      o_pll_ref  <= pll_ref_reg;
    end
  end

  // prescaler on timing clock; halt in wait or debug
  wire halt = (wait_s[1] & rti_ctrl_reg[clk_fn_pkg::RTI_SW_BIT]) |
              (dbg_s[1] & rti_ctrl_reg[clk_fn_pkg::RTI_SB_BIT]);
  wire tick = crystal_timing_clock_rise & ~halt;
  logic [22:0] pre_reg;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) pre_reg <= 23'h0;
    else if (i_ce && tick) pre_reg <= pre_reg + 23'h1;
  end
  // base stage end: 2^13 or 4
  wire [4:0] base_exp = rti_ctrl_reg[clk_fn_pkg::RTI_BY_BIT] ?
                        5'(clk_fn_pkg::BYP_EXP) : 5'(clk_fn_pkg::RTI_BASE_EXP);
  function automatic logic rollover(input logic [22:0] p, input logic [4:0] e);
    logic [22:0] m;
    m = (23'h1 << e) - 23'h1;
    rollover = (p & m) == m;
  endfunction
  wire [2:0] rate = rti_ctrl_reg[2:0];
  wire [4:0] rti_exp = 5'(base_exp + 5'(rate) - 5'h1);
  assign flag_set = i_ce && tick && rate != 3'h0 && rollover(pre_reg, rti_exp);
  assign o_periodic_irq = flag_reg & rti_ctrl_reg[clk_fn_pkg::RTI_IE_BIT];

  // watchdog
  // rate to exponent: 13,15,17,19,21,22,23
  logic [4:0] wd_exp;
  always_comb begin
    unique case (wd_ctrl_reg[2:0])
      3'h1:    wd_exp = 5'h0D;
      3'h2:    wd_exp = 5'h0F;
      3'h3:    wd_exp = 5'h11;
      3'h4:    wd_exp = 5'h13;
      3'h5:    wd_exp = 5'h15;
      3'h6:    wd_exp = 5'h16;
      default: wd_exp = 5'h17;
    endcase
  end
  wire wd_on = wd_ctrl_reg[2:0] != 3'h0;
  logic [23:0] wd_cnt_reg;
  logic        armed_reg;
  wire [23:0] wd_limit = 24'h1 << wd_exp;
  wire        in_window = wd_cnt_reg >= (wd_limit - (wd_limit >> 2));
  wire svc_55 = wr_svc && i_wdata == clk_fn_pkg::SVC_FIRST;
  wire svc_aa = wr_svc && i_wdata == clk_fn_pkg::SVC_SECOND;
  wire win    = wd_ctrl_reg[clk_fn_pkg::WD_WIN_BIT];
  wire bad_val = wr_svc && !svc_55 && !svc_aa;
  wire early   = wr_svc && win && !in_window;
  wire expire  = tick && wd_cnt_reg >= wd_limit - 24'h1;
  wire wd_fail = wd_on && (bad_val || early || expire);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      wd_cnt_reg <= 24'h0; armed_reg <= 1'b0;
    end else if (i_ce) begin
      if (svc_55) armed_reg <= 1'b1;
      if (svc_aa && armed_reg) begin
        wd_cnt_reg <= 24'h0;
        armed_reg  <= 1'b0;
      end else if (tick && wd_on) wd_cnt_reg <= wd_cnt_reg + 24'h1;
    end
  end

  logic [15:0] mon_cnt_reg;
  wire mon_on = wd_ctrl_reg[clk_fn_pkg::WD_CME_BIT];
  wire mon_fail = mon_on && mon_cnt_reg >= 16'(MON_CYCLES);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) mon_cnt_reg <= 16'h0;
    else if (i_ce) begin
      if (!mon_on || osc_edge) mon_cnt_reg <= 16'h0;
      else if (!mon_fail) mon_cnt_reg <= mon_cnt_reg + 16'h1;
    end
  end
  wire disr = wd_ctrl_reg[clk_fn_pkg::WD_DIS_BIT];
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_wdg_reset <= 1'b0; o_mon_reset <= 1'b0;
    end else if (i_ce) begin
      // reset requests held until the system reset arrives
      o_wdg_reset <= o_wdg_reset | (wd_fail & ~disr);
      o_mon_reset <= o_mon_reset | (mon_fail & ~disr);
    end
  end

  // assertions
  property p_irq_gate;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      o_periodic_irq |-> (flag_reg && rti_ctrl_reg[clk_fn_pkg::RTI_IE_BIT]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without flag");
  property p_flag_set;
    @(posedge i_sys_clk) disable iff (!i_rstn) flag_set |=> flag_reg;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_bad_val;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_ce && bad_val && wd_on && !disr) |=> o_wdg_reset;
  endproperty
  a_bad_val: assert property (p_bad_val) else $error("bad service no reset");
  property p_early;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_ce && early && wd_on && !disr) |=> o_wdg_reset;
  endproperty
  a_early: assert property (p_early) else $error("early service no reset");
  property p_mcs_limp;
    @(posedge i_sys_clk) disable iff (!i_rstn) (i_ce && limp) |=> !o_module_slow_sel;
  endproperty
  a_mcs_limp: assert property (p_mcs_limp) else $error("module select not forced");
  property p_halt;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_ce && switching) |=> (o_cpu_halt && !o_clock_select);
  endproperty
  a_halt: assert property (p_halt) else $error("switch without halt");
  property p_pll_sel;
    @(posedge i_sys_clk) disable iff (!i_rstn) o_sys_sel_pll |-> !o_sys_sel_slow;
  endproperty
  a_pll_sel: assert property (p_pll_sel) else $error("both selects");
  property p_mon;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_ce && mon_fail && !disr) |=> o_mon_reset;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor no reset");

  // service steps and source switch as sequences
  sequence s_svc_first;
    i_ce && svc_55;
  endsequence
  sequence s_svc_second;
    i_ce && svc_aa && armed_reg;
  endsequence
  sequence s_switch;
    i_ce && switching;
  endsequence
  property p_svc_arm;
    @(posedge i_sys_clk) disable iff (!i_rstn) s_svc_first |=> armed_reg;
  endproperty
  a_svc_arm: assert property (p_svc_arm) else $error("first step not armed");
  property p_svc_restart;
    @(posedge i_sys_clk) disable iff (!i_rstn) s_svc_second |=> (wd_cnt_reg == 24'h0 && !armed_reg);
  endproperty
  a_svc_restart: assert property (p_svc_restart) else $error("no restart");
  property p_expire;
    @(posedge i_sys_clk) disable iff (!i_rstn) (i_ce && wd_on && expire && !disr) |=> o_wdg_reset;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry no reset");
  property p_flag_clr;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_ce && wr_flag && i_wdata[clk_fn_pkg::RTI_FLAG_BIT] && !flag_set) |=> !flag_reg;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
  property p_irq_off;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      !rti_ctrl_reg[clk_fn_pkg::RTI_IE_BIT] |-> !o_periodic_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_rate_off;
    @(posedge i_sys_clk) disable iff (!i_rstn) (rate == 3'h0) |-> !flag_set;
  endproperty
  a_rate_off: assert property (p_rate_off) else $error("flag at rate zero");
  property p_byp_normal;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_ce && wr_rti && !i_special_mode) |=> $stable(rti_ctrl_reg[clk_fn_pkg::RTI_BY_BIT]);
  endproperty
  a_byp_normal: assert property (p_byp_normal) else $error("bypass written");
  property p_sw_once;
    @(posedge i_sys_clk) disable iff (!i_rstn) (i_ce && wr_rti && !i_special_mode && once_sw_reg)
      |=> $stable(rti_ctrl_reg[clk_fn_pkg::RTI_SW_BIT]);
  endproperty
  a_sw_once: assert property (p_sw_once) else $error("stop-in-wait rewritten");
  property p_sb_once;
    @(posedge i_sys_clk) disable iff (!i_rstn) (i_ce && wr_rti && !i_special_mode && once_sb_reg)
      |=> $stable(rti_ctrl_reg[clk_fn_pkg::RTI_SB_BIT]);
  endproperty
  a_sb_once: assert property (p_sb_once) else $error("stop-in-debug rewritten");
  property p_halt_pre;
    @(posedge i_sys_clk) disable iff (!i_rstn) (i_ce && halt) |=> $stable(pre_reg);
  endproperty
  a_halt_pre: assert property (p_halt_pre) else $error("prescaler ran while halted");
  property p_switch_done;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      s_switch ##1 (i_ce && !switching)[*5] |=> (o_clock_select && !o_cpu_halt);
  endproperty
  a_switch_done: assert property (p_switch_done) else $error("switch never ends");
  property p_div_out;
    @(posedge i_sys_clk) disable iff (!i_rstn) i_ce |=> (o_slow_div == $past(slow_div_reg) &&
      o_pll_mul == $past(pll_mul_reg) && o_pll_ref == $past(pll_ref_reg));
  endproperty
  a_div_out: assert property (p_div_out) else $error("divider output stale");
  property p_sel_out;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      i_ce |=> (o_sys_sel_pll == $past(sel_pll) && o_sys_sel_slow == $past(sel_slow));
  endproperty
  a_sel_out: assert property (p_sel_out) else $error("source select stale");
  property p_mux_out;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      i_ce |=> (o_can_from_sys == $past(clk_sel_reg[clk_fn_pkg::CS_CAN_BIT]) &&
                o_debug_from_e == $past(clk_sel_reg[clk_fn_pkg::CS_DBG_BIT]));
  endproperty
  a_mux_out: assert property (p_mux_out) else $error("can or debug select stale");
  property p_vco;
    @(posedge i_sys_clk) disable iff (!i_rstn) i_ce |=> (o_periph_from_vco == $past(limp));
  endproperty
  a_vco: assert property (p_vco) else $error("limp clocks not from vco");
  property p_mon_clr;
    @(posedge i_sys_clk) disable iff (!i_rstn) (i_ce && mon_on && osc_edge) |=> mon_cnt_reg == 16'h0;
  endproperty
  a_mon_clr: assert property (p_mon_clr) else $error("monitor not restarted");
endmodule

// ===== clk_fn_pkg.sv
// Summary of operation
// - slow clock is oscillator over twice divider; divider zero passes it through
// - pll clock is 2 x osc x (multiplier+1) / (reference divider+1)
// - e and peripheral clocks are system/2; timing clock slow/2; debug base osc/2
// - pll select wins; otherwise slow select picks oscillator or slow clock
// - during source switch hold clock select low and halt cpu
// - module clock is peripheral clock, or timing clock when module select set
// - limp-home forces module select output to zero; read returns latched bit
// - limp-home feeds peripheral, e, debug, module and timing clocks from vco
// - can clock picks osc or system; debug clock picks debug base or e
// - any other service value resets immediately
// - windowed mode accepts service only in last quarter; early write resets
// - three-bit rate picks seven periods; expiry resets
// - clock monitor resets when no oscillator edge within rc delay
// - periodic irq requested while flag and enable both set
// - stop-in-wait halts periodic timer and watchdog in wait; write once normal
// - stop-in-debug halts both in debug mode; write once normal
// - bypass makes prescaler divide by 4 not 2^13; special modes only
// - rate zero off; codes 1..7 select 2^13..2^19
// - flag set on time-out, cleared by writing one
package clk_fn_pkg;
  localparam logic [7:0] ADDR_RTI_CTRL  = 8'h14;
  localparam logic [7:0] ADDR_RTI_FLAG  = 8'h15;
  localparam logic [7:0] ADDR_WDG_CTRL  = 8'h16;
  localparam logic [7:0] ADDR_WDG_SVC   = 8'h17;
  localparam logic [7:0] ADDR_CLK_SEL   = 8'h3D;
  localparam logic [7:0] ADDR_SLOW_DIV  = 8'h3E;
  localparam logic [7:0] ADDR_PLL_MUL   = 8'h38;
  localparam logic [7:0] ADDR_PLL_REF   = 8'h39;
  // rti control fields
  localparam int RTI_IE_BIT = 7;
  localparam int RTI_SW_BIT = 6;
  localparam int RTI_SB_BIT = 5;
  localparam int RTI_BY_BIT = 3;
  localparam int RTI_FLAG_BIT = 7;
  // watchdog control fields
  localparam int WD_CME_BIT = 7;
  localparam int WD_WIN_BIT = 4;
  localparam int WD_DIS_BIT = 3;
  localparam logic [7:0] WD_CTRL_RST = 8'h07;
  // clock select fields
  localparam int CS_BUS_PLL_SELECT_BIT = 6;
  localparam int CS_BUS_SLOW_SELECT_BIT = 5;
  localparam int CS_MCS_BIT  = 2;
  localparam int CS_CAN_BIT  = 1;
  localparam int CS_DBG_BIT  = 0;
  localparam logic [7:0] SVC_FIRST  = 8'h55;
  localparam logic [7:0] SVC_SECOND = 8'hAA;
  localparam int RTI_BASE_EXP = 13;
  localparam int BYP_EXP      = 2;
  // clock monitor rc delay, ns, system clock 50 ns
  localparam int CM_DELAY_NS  = 2000;
  localparam int CLK_PER_NS   = 50;
  localparam int CM_CYCLES    = CM_DELAY_NS / CLK_PER_NS;
  localparam int SWITCH_CYC   = 4;
endpackage

// ===== clock_select_rti_watchdog_tb_top.sv
`timescale 1ns/1ps
module clock_select_rti_watchdog_tb_top;
  logic       i_sys_clk;
  logic       i_rstn;
  logic       i_ce;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] o_rdata;
  logic       i_special_mode;
  logic       i_wait_mode;
  logic       i_debug_mode;
  logic       i_limp_home;
  logic       i_osc_tick;
  logic       i_crystal_timing_clock_tick;
  logic       o_sys_sel_pll, o_sys_sel_slow, o_clock_select, o_cpu_halt;
  logic       o_module_slow_sel, o_periph_from_vco, o_can_from_sys, o_debug_from_e;
  logic [5:0] o_slow_div;
  logic [7:0] o_pll_mul, o_pll_ref;
  logic       o_periodic_irq, o_wdg_reset, o_mon_reset;
  logic       osc_run;
  int         n_mismatch;
  int         samples_checked;

  clock_select_rti_watchdog #(.MON_CYCLES(8)) u_clock_select_rti_watchdog (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_special_mode(i_special_mode), .i_wait_mode(i_wait_mode),
    .i_debug_mode(i_debug_mode), .i_limp_home(i_limp_home), .i_osc_tick(i_osc_tick),
    .i_crystal_timing_clock_tick(i_crystal_timing_clock_tick), .o_sys_sel_pll(o_sys_sel_pll),
    .o_sys_sel_slow(o_sys_sel_slow), .o_clock_select(o_clock_select),
    .o_cpu_halt(o_cpu_halt), .o_module_slow_sel(o_module_slow_sel),
    .o_periph_from_vco(o_periph_from_vco), .o_can_from_sys(o_can_from_sys),
    .o_debug_from_e(o_debug_from_e), .o_slow_div(o_slow_div), .o_pll_mul(o_pll_mul),
    .o_pll_ref(o_pll_ref), .o_periodic_irq(o_periodic_irq), .o_wdg_reset(o_wdg_reset),
    .o_mon_reset(o_mon_reset));

  // 20 mhz system clock
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // oscillator activity seen by the monitor
  always @(posedge i_sys_clk) if (osc_run) i_osc_tick <= ~i_osc_tick;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  // read data stands in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  // timing clock rising edges, each level held two cycles
  task automatic xedges(input int n);
    repeat (n) begin
      @(posedge i_sys_clk) i_crystal_timing_clock_tick <= 1'b1;
      @(posedge i_sys_clk);
      @(posedge i_sys_clk) i_crystal_timing_clock_tick <= 1'b0;
      @(posedge i_sys_clk);
    end
    #1;
  endtask

  task automatic do_reset();
    @(posedge i_sys_clk) i_rstn <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    cyc(3);
  endtask

  // bypass refused and stop bits used up in normal mode
  task automatic t_normal_mode();
    wr(8'h14, 8'h28);
    rdchk(8'h14, 8'h20);
    wr(8'h14, 8'h00);
    rdchk(8'h14, 8'h20);
  endtask

  // system source, module, can and debug selects
  task automatic t_clock_select();
    wr(8'h3D, 8'h67);
    cyc(2);
    chk(8'({o_clock_select, o_cpu_halt}), 8'h01);
    cyc(10);
    chk(8'({o_clock_select, o_cpu_halt}), 8'h02);
    chk(8'({o_sys_sel_pll, o_sys_sel_slow}), 8'h02);
    chk(8'({o_module_slow_sel, o_can_from_sys, o_debug_from_e}), 8'h07);
    rdchk(8'h3D, 8'h67);
    wr(8'h38, 8'h12);
    cyc(2);
    chk(o_pll_mul, 8'h00);
    wr(8'h3D, 8'h20);
    cyc(12);
    chk(8'({o_sys_sel_pll, o_sys_sel_slow}), 8'h01);
    chk(8'({o_module_slow_sel, o_can_from_sys, o_debug_from_e}), 8'h00);
    wr(8'h38, 8'h12);
    wr(8'h39, 8'h03);
    wr(8'h3E, 8'h3F);
    cyc(2);
    chk(o_pll_mul, 8'h12);
    chk(o_pll_ref, 8'h03);
    chk(8'(o_slow_div), 8'h3F);
  endtask

  // limp-home clears the module select output and sets the vco output
  task automatic t_limp();
    wr(8'h3D, 8'h24);
    cyc(10);
    chk(8'(o_module_slow_sel), 8'h01);
    i_limp_home <= 1'b1;
    cyc(6);
    chk(8'({o_module_slow_sel, o_periph_from_vco}), 8'h01);
    rdchk(8'h3D, 8'h24);
    i_limp_home <= 1'b0;
    cyc(6);
    chk(8'({o_module_slow_sel, o_periph_from_vco}), 8'h02);
  endtask

  // periodic flag with bypassed prescaler, rate one gives four edges
  task automatic t_periodic();
    wr(8'h14, 8'h89);
    xedges(3);
    chk(8'(o_periodic_irq), 8'h00);
    xedges(1);
    cyc(3);
    chk(8'(o_periodic_irq), 8'h01);
    rdchk(8'h15, 8'h80);
    wr(8'h15, 8'h80);
    cyc(1);
    chk(8'(o_periodic_irq), 8'h00);
    wr(8'h14, 8'h09);
    xedges(4);
    chk(8'(o_periodic_irq), 8'h00);
    rdchk(8'h15, 8'h80);
    wr(8'h15, 8'h80);
    wr(8'h14, 8'h88);
    xedges(8);
    rdchk(8'h15, 8'h00);
  endtask

  // halt in wait or debug mode, resume afterwards
  task automatic t_stop(input bit dbg);
    wr(8'h15, 8'h80);
    wr(8'h14, dbg ? 8'hA9 : 8'hC9);
    if (dbg) i_debug_mode <= 1'b1;
    else i_wait_mode <= 1'b1;
    cyc(4);
    xedges(8);
    chk(8'(o_periodic_irq), 8'h00);
    i_debug_mode <= 1'b0;
    i_wait_mode  <= 1'b0;
    cyc(4);
    xedges(4);
    cyc(3);
    chk(8'(o_periodic_irq), 8'h01);
  endtask

  // oscillator stops while monitor enabled
  task automatic t_monitor();
    osc_run <= 1'b1;
    wr(8'h16, 8'h87);
    cyc(20);
    chk(8'(o_mon_reset), 8'h00);
    osc_run <= 1'b0;
    cyc(20);
    chk(8'(o_mon_reset), 8'h01);
  endtask

  // service sequence, bad value, window and expiry
  task automatic t_watchdog();
    wr(8'h17, 8'h55);
    wr(8'h17, 8'hAA);
    cyc(3);
    chk(8'(o_wdg_reset), 8'h00);
    rdchk(8'h17, 8'h00);
    wr(8'h17, 8'h33);
    cyc(2);
    chk(8'(o_wdg_reset), 8'h01);
    do_reset();
    wr(8'h16, 8'h11);
    xedges(6400);
    wr(8'h17, 8'h55);
    wr(8'h17, 8'hAA);
    cyc(3);
    chk(8'(o_wdg_reset), 8'h00);
    xedges(8100);
    chk(8'(o_wdg_reset), 8'h00);
    xedges(200);
    chk(8'(o_wdg_reset), 8'h01);
    do_reset();
    wr(8'h16, 8'h11);
    wr(8'h17, 8'h55);
    cyc(2);
    chk(8'(o_wdg_reset), 8'h01);
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge i_sys_clk);
    n_mismatch++;
    final_report();
  end

  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    i_rstn = 1'b0;
    i_ce = 1'b1;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_special_mode = 1'b0;
    i_wait_mode = 1'b0;
    i_debug_mode = 1'b0;
    i_limp_home = 1'b0;
    i_osc_tick = 1'b0;
    i_crystal_timing_clock_tick = 1'b0;
    osc_run = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    cyc(3);
    t_normal_mode();
    i_special_mode <= 1'b1;
    t_clock_select();
    t_limp();
    t_periodic();
    t_stop(1'b0);
    t_stop(1'b1);
    t_monitor();
    do_reset();
    t_watchdog();
    final_report();
  end
endmodule
